// >>> logic/isc_ctrl.v
/*
  Register block and SCL timing engine of a two-wire serial controller.
  Holds control, status, data, count, prescaler, SCL period and own-address
  registers and drives the serial unit's command outputs.
  Assumes a byte-shift engine on the same clock reports bus events as
  one-cycle pulses and levels, and that pin levels reach it unsynchronised.
*/
// Chosen here: strobed register access and the address map.
// Functional notes
// - Transmit DMA select routes tx data via DMA, masks tx-ready enable.
// - With sync set, two-wire bit selects SPI (0) or I2C (1).
// - Ten-bit address select chooses 7-bit (0) or 10-bit (1) addressing.
// - Loopback feeds SDA back to receiver only as master transmitter.
// - Sync bit chooses UART (0) or SPI/I2C (1) operation.
// - Master select cleared by hardware on arbitration loss or generated STOP.
// - Enable bit resets to 1; cleared when I2C and sync first set.
// - Word mode: byte-wide data writes leave the data register unchanged.
// - Repeat mode 0 uses byte count; repeat mode 1 ignores it.
// - Clock source 00 none, 01 aux, 1x sub-main; arbitration loss uses SCL.
// - Transmit bit sets direction as master; slave uses address R/W bit.
// - Start-byte with START sends START plus 01h, no STOP, then clears.
// - START and STOP command bits clear once their condition is generated.
// - Clock-held-low flag shows slave stretching SCL while master.
// - Single-byte flag tells full word or lower byte only, word mode.
// - Underflow and overrun flags set by data starvation and overrun.
// - Bus busy set by START, cleared by STOP or enable low.
// - Byte count drives master counting; must be even in word mode.
// - Internal clock is input clock divided by prescaler plus one.
// - SCL high/low = (setting+2)*(prescaler+1), minimum 5 units.
// - Receive DMA select moves rx data via DMA, masks rx-ready enable.
`timescale 1ns/1ps
`default_nettype none
`include "isc_regs.vh"

module isc_ctrl #(
  parameter ADDR_W = 8
) (
  input  wire              clk_sys_i,
  input  wire              arst_n_i,
  // Register port
  input  wire [ADDR_W-1:0] reg_addr_i,
  input  wire [15:0]       reg_wdata_i,
  input  wire              reg_byte_wr_i,
  input  wire              reg_wr_i,
  input  wire              reg_rd_i,
  output reg  [15:0]       reg_rdata_o,
  // Clock sources (ticks on clk_sys_i)
  input  wire              aux_clk_tick_i,
  input  wire              sub_main_clock_tick_i,
  // Pins, raw
  input  wire              scl_pin_i,
  input  wire              sda_pin_i,
  // Shift engine events
  input  wire              start_seen_i,
  input  wire              stop_seen_i,
  input  wire              arb_lost_i,
  input  wire              start_done_i,
  input  wire              stop_done_i,
  input  wire              tx_starved_i,
  input  wire              rx_overrun_i,
  input  wire              rx_byte_i,
  input  wire              rx_word_i,
  input  wire [15:0]       rx_data_i,
  input  wire              engine_active_i,
  input  wire              tx_ready_irq_enable_i,
  input  wire              rx_ready_irq_enable_i,
  // Controls to engine
  output wire              i2c_mode_o,
  output wire              spi_mode_o,
  output wire              uart_mode_o,
  output wire              ten_bit_address_select_o,
  output wire              master_select_o,
  output wire              transmit_dir_o,
  output wire              loopback_o,
  output wire              start_req_o,
  output wire              stop_req_o,
  output wire              start_byte_req_o,
  output wire [7:0]        start_byte_o,
  output wire              count_active_o,
  output wire [7:0]        byte_count_o,
  output wire [15:0]       tx_data_o,
  output wire [15:0]       own_address_o,
  output wire              tx_dma_req_o,
  output wire              rx_dma_req_o,
  output wire              tx_irq_gate_o,
  output wire              rx_irq_gate_o,
  output wire              use_ext_scl_o,
  output reg               bit_tick_o,
  output reg               scl_out_o,
  output reg               scl_oe_n_o
);

  reg  [7:0]  serial_unit_control;
  reg  [7:0]  transfer_control;
  reg  [15:0] data_buffer;
  reg  [7:0]  byte_count;
  reg  [7:0]  clock_prescaler;
  reg  [7:0]  scl_high_period;
  reg  [7:0]  scl_low_period;
  reg  [6:0]  local_bus_address;
  reg         mode_seen;
  reg         clock_held_low_flag;
  reg         single_byte_flag;
  reg         tx_underflow_flag;
  reg         rx_overrun_flag;
  reg         bus_busy_flag;
  reg  [1:0]  scl_sync;
  reg  [1:0]  sda_sync;
  reg         arb_fallback;
  reg  [7:0]  psc_cnt;
  reg  [8:0]  phase_cnt;
  reg  [15:0] next_rdata;
  reg         src_tick;
  wire        module_enable;
  wire        wr_unit;
  wire        wr_xfer;
  wire [8:0]  high_units;
  wire [8:0]  low_units;

  assign module_enable = serial_unit_control[`ISC_UC_ENABLE];
  assign wr_unit = reg_wr_i && (reg_addr_i == `ISC_ADDR_UNIT_CTL);
  assign wr_xfer = reg_wr_i && (reg_addr_i == `ISC_ADDR_XFER_CTL);

  // Mode decode
  assign uart_mode_o  = ~serial_unit_control[`ISC_UC_SYNC];
  assign i2c_mode_o   = serial_unit_control[`ISC_UC_SYNC] &
                        serial_unit_control[`ISC_UC_TWO_WIRE];
  assign spi_mode_o   = serial_unit_control[`ISC_UC_SYNC] &
                        ~serial_unit_control[`ISC_UC_TWO_WIRE];
  assign ten_bit_address_select_o = serial_unit_control[`ISC_UC_TEN_BIT];
  assign master_select_o = serial_unit_control[`ISC_UC_MASTER];
  // Slave direction comes from the engine's address R/W bit
  assign transmit_dir_o = master_select_o & transfer_control[`ISC_TC_TRANSMIT];
  assign loopback_o = serial_unit_control[`ISC_UC_LOOPBACK] & transmit_dir_o;
  assign start_req_o = transfer_control[`ISC_TC_START] & module_enable;
  assign stop_req_o  = transfer_control[`ISC_TC_STOP] & module_enable;
  assign start_byte_req_o = transfer_control[`ISC_TC_START_BYTE] &
                            transfer_control[`ISC_TC_START] & master_select_o;
  assign start_byte_o = `ISC_START_BYTE_VAL;
  assign count_active_o = ~transfer_control[`ISC_TC_REPEAT] & master_select_o;
  assign byte_count_o = byte_count;
  assign tx_data_o = data_buffer;
  assign own_address_o = {9'h000, local_bus_address};
  // DMA select takes over the ready events and masks the ready enables
  assign tx_dma_req_o  = serial_unit_control[`ISC_UC_TX_DMA];
  assign rx_dma_req_o  = serial_unit_control[`ISC_UC_RX_DMA];
  assign tx_irq_gate_o = tx_ready_irq_enable_i & ~tx_dma_req_o;
  assign rx_irq_gate_o = rx_ready_irq_enable_i & ~rx_dma_req_o;
  assign use_ext_scl_o = arb_fallback;

  // Pin synchronisers; first stage read only by the second
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_pin_i};
      sda_sync <= {sda_sync[0], sda_pin_i};
    end
  end

  // Control registers; hardware clears win over software sets
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_unit_control <= `ISC_UC_RESET;
      transfer_control    <= `ISC_ZERO8;
      mode_seen           <= 1'b0;
      arb_fallback        <= 1'b0;
    end else begin
      if (wr_unit) begin
        serial_unit_control <= reg_wdata_i[7:0];
        // First entry into two-wire mode after reset drops the enable
        if (!mode_seen && reg_wdata_i[`ISC_UC_TWO_WIRE] &&
            reg_wdata_i[`ISC_UC_SYNC]) begin
          serial_unit_control[`ISC_UC_ENABLE] <= 1'b0;
          mode_seen <= 1'b1;
        end
      end
      if (arb_lost_i || stop_done_i)
        serial_unit_control[`ISC_UC_MASTER] <= 1'b0;
      if (arb_lost_i && master_select_o)
        arb_fallback <= 1'b1;
      else if (stop_seen_i || !module_enable)
        arb_fallback <= 1'b0;
      // Writes honoured only while disabled, commands excepted
      if (wr_xfer && !module_enable)
        transfer_control <= reg_wdata_i[7:0];
      else if (wr_xfer)
        transfer_control[`ISC_TC_START_BYTE:`ISC_TC_START] <=
          reg_wdata_i[`ISC_TC_START_BYTE:`ISC_TC_START];
      if (start_done_i) begin
        transfer_control[`ISC_TC_START]      <= 1'b0;
        transfer_control[`ISC_TC_START_BYTE] <= 1'b0;
      end
      if (stop_done_i)
        transfer_control[`ISC_TC_STOP] <= 1'b0;
    end
  end

  // Data, count, timing and address registers
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_buffer       <= `ISC_ZERO16;
      byte_count        <= `ISC_ZERO8;
      clock_prescaler   <= `ISC_ZERO8;
      scl_high_period   <= `ISC_ZERO8;
      scl_low_period    <= `ISC_ZERO8;
      local_bus_address <= 7'h00;
    end else begin
      if (rx_byte_i || rx_word_i)
        data_buffer <= rx_data_i;
      else if (reg_wr_i && reg_addr_i == `ISC_ADDR_DATA) begin
        if (!transfer_control[`ISC_TC_WORD])
          data_buffer <= {8'h00, reg_wdata_i[7:0]};
        else if (!reg_byte_wr_i)
          data_buffer <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `ISC_ADDR_COUNT)
        byte_count <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == `ISC_ADDR_PRESCALE)
        clock_prescaler <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == `ISC_ADDR_SCL_HIGH && !module_enable)
        scl_high_period <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == `ISC_ADDR_SCL_LOW && !module_enable)
        scl_low_period <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == `ISC_ADDR_OWN_ADDR)
        local_bus_address <= reg_wdata_i[6:0];
    end
  end

  // Status flags: set by hardware, no software write path
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_held_low_flag <= 1'b0;
      single_byte_flag    <= 1'b0;
      tx_underflow_flag   <= 1'b0;
      rx_overrun_flag     <= 1'b0;
      bus_busy_flag       <= 1'b0;
    end else begin
      // SCL released by us yet low: a slave is stretching
      clock_held_low_flag <= master_select_o & scl_oe_n_o & ~scl_sync[1];
      if (rx_word_i)
        single_byte_flag <= 1'b0;
      else if (rx_byte_i)
        single_byte_flag <= transfer_control[`ISC_TC_WORD];
      // Set wins over the clear by disable
      if (tx_starved_i)
        tx_underflow_flag <= 1'b1;
      else if (!module_enable)
        tx_underflow_flag <= 1'b0;
      if (rx_overrun_i)
        rx_overrun_flag <= 1'b1;
      else if (!module_enable)
        rx_overrun_flag <= 1'b0;
      if (!module_enable || stop_seen_i)
        bus_busy_flag <= 1'b0;
      else if (start_seen_i)
        bus_busy_flag <= 1'b1;
    end
  end

  // Clock source selection
  always @* begin
    case (transfer_control[`ISC_TC_CLK_HI:`ISC_TC_CLK_LO])
      `ISC_CLK_NONE: src_tick = 1'b0;
      `ISC_CLK_AUX:  src_tick = aux_clk_tick_i;
      default:       src_tick = sub_main_clock_tick_i;
    endcase
  end

  // SCL periods in prescaled units, floor of five
  assign high_units = (scl_high_period < `ISC_SCL_MIN_SET) ?
                      ({1'b0, `ISC_SCL_MIN_SET} + `ISC_SCL_OFFSET) :
                      ({1'b0, scl_high_period} + `ISC_SCL_OFFSET);
  assign low_units  = (scl_low_period < `ISC_SCL_MIN_SET) ?
                      ({1'b0, `ISC_SCL_MIN_SET} + `ISC_SCL_OFFSET) :
                      ({1'b0, scl_low_period} + `ISC_SCL_OFFSET);

  // Prescaler and SCL generator; waits while a slave stretches SCL
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      psc_cnt    <= `ISC_ZERO8;
      phase_cnt  <= 9'h000;
      bit_tick_o <= 1'b0;
      scl_out_o  <= 1'b0;
      scl_oe_n_o <= 1'b1;
    end else begin
      bit_tick_o <= 1'b0;
      scl_out_o  <= 1'b0;
      if (!module_enable || !master_select_o || arb_fallback) begin
        psc_cnt    <= `ISC_ZERO8;
        phase_cnt  <= 9'h000;
        scl_oe_n_o <= 1'b1;
      end else if (src_tick) begin
        if (psc_cnt >= clock_prescaler) begin
          psc_cnt    <= `ISC_ZERO8;
          bit_tick_o <= 1'b1;
          if (scl_oe_n_o && !scl_sync[1]) begin
            phase_cnt <= 9'h000;
          end else if (phase_cnt + 9'h001 >= (scl_oe_n_o ? high_units : low_units)) begin
            phase_cnt  <= 9'h000;
            scl_oe_n_o <= ~scl_oe_n_o;
          end else begin
            phase_cnt <= phase_cnt + 9'h001;
          end
        end else begin
          psc_cnt <= psc_cnt + `ISC_ONE8;
        end
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always @* begin
    next_rdata = `ISC_ZERO16;
    case (reg_addr_i)
      `ISC_ADDR_UNIT_CTL:  next_rdata = {8'h00, serial_unit_control};
      `ISC_ADDR_XFER_CTL:  next_rdata = {8'h00, transfer_control};
      `ISC_ADDR_DATA_STAT: next_rdata = {10'h000, engine_active_i, clock_held_low_flag,
                                         single_byte_flag, tx_underflow_flag,
                                         rx_overrun_flag, bus_busy_flag};
      `ISC_ADDR_COUNT:     next_rdata = {8'h00, byte_count};
      `ISC_ADDR_PRESCALE:  next_rdata = {8'h00, clock_prescaler};
      `ISC_ADDR_SCL_HIGH:  next_rdata = {8'h00, scl_high_period};
      `ISC_ADDR_SCL_LOW:   next_rdata = {8'h00, scl_low_period};
      `ISC_ADDR_DATA:      next_rdata = transfer_control[`ISC_TC_WORD] ?
                                        data_buffer : {8'h00, data_buffer[7:0]};
      `ISC_ADDR_OWN_ADDR:  next_rdata = own_address_o;
      default:             next_rdata = `ISC_ZERO16;
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i)
      reg_rdata_o <= `ISC_ZERO16;
    else
      reg_rdata_o <= reg_rd_i ? next_rdata : `ISC_ZERO16;
  end

  // Sampled SDA is not used locally; engine takes loopback flag
  wire unused_sda = sda_sync[1];

endmodule // isc_ctrl
`default_nettype wire

// >>> logic/isc_regs.vh
/*
  Register offsets, field positions, reset values and timing constants
  of the two-wire serial controller register block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef ISC_REGS_VH
`define ISC_REGS_VH

// Register offsets (plain register port, byte addresses)
`define ISC_ADDR_COUNT      8'h52
`define ISC_ADDR_UNIT_CTL   8'h70
`define ISC_ADDR_XFER_CTL   8'h71
`define ISC_ADDR_DATA_STAT  8'h72
`define ISC_ADDR_PRESCALE   8'h73
`define ISC_ADDR_SCL_HIGH   8'h74
`define ISC_ADDR_SCL_LOW    8'h75
`define ISC_ADDR_DATA       8'h76
`define ISC_ADDR_OWN_ADDR   8'h18

// Serial unit control fields
`define ISC_UC_RX_DMA       7
`define ISC_UC_TX_DMA       6
`define ISC_UC_TWO_WIRE     5
`define ISC_UC_TEN_BIT      4
`define ISC_UC_LOOPBACK     3
`define ISC_UC_SYNC         2
`define ISC_UC_MASTER       1
`define ISC_UC_ENABLE       0
`define ISC_UC_RESET        8'h01

// Transfer control fields
`define ISC_TC_WORD         7
`define ISC_TC_REPEAT       6
`define ISC_TC_CLK_HI       5
`define ISC_TC_CLK_LO       4
`define ISC_TC_TRANSMIT     3
`define ISC_TC_START_BYTE   2
`define ISC_TC_STOP         1
`define ISC_TC_START        0

// Clock source codes
`define ISC_CLK_NONE        2'h0
`define ISC_CLK_AUX         2'h1

// Misc constants
`define ISC_ZERO8           8'h00
`define ISC_ZERO16          16'h0000
`define ISC_ONE8            8'h01
`define ISC_START_BYTE_VAL  8'h01
`define ISC_SCL_MIN_SET     8'h03
`define ISC_SCL_OFFSET      9'h002
`define ISC_OWN_ADDR_MASK   16'h007f

`endif

// >>> tb/isc_ctrl_properties.sv
/*
  Port assertions for the two-wire serial controller register block.
  Assumes a bind onto isc_ctrl and the offsets and fields of isc_regs.vh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "isc_regs.vh"
module isc_ctrl_chk #(
  parameter ADDR_W = 8
) (
  input wire logic              clk_sys_i,
  input wire logic              arst_n_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [15:0]       reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [15:0]       reg_rdata_o,
  input wire logic              arb_lost_i,
  input wire logic              start_done_i,
  input wire logic              stop_done_i,
  input wire logic              i2c_mode_o,
  input wire logic              uart_mode_o,
  input wire logic              master_select_o,
  input wire logic              transmit_dir_o,
  input wire logic              loopback_o,
  input wire logic              start_req_o,
  input wire logic              stop_req_o,
  input wire logic [7:0]        start_byte_o,
  input wire logic              tx_dma_req_o,
  input wire logic              rx_dma_req_o,
  input wire logic              tx_irq_gate_o,
  input wire logic              rx_irq_gate_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Software writes may race hardware clears, so they are excluded
  wire logic uc_wr = reg_wr_i && reg_addr_i == `ISC_ADDR_UNIT_CTL;
  wire logic tc_wr = reg_wr_i && reg_addr_i == `ISC_ADDR_XFER_CTL;
  property p_mode_i2c;
    uc_wr |=> i2c_mode_o == ($past(reg_wdata_i[`ISC_UC_TWO_WIRE]) && $past(reg_wdata_i[`ISC_UC_SYNC]));
  endproperty
  a_mode_i2c: assert property (p_mode_i2c) else $error("two-wire mode wrong");
  property p_mode_uart;
    uc_wr |=> uart_mode_o != $past(reg_wdata_i[`ISC_UC_SYNC]);
  endproperty
  a_mode_uart: assert property (p_mode_uart) else $error("uart mode wrong");
  property p_mst_arb;
    master_select_o && arb_lost_i && !uc_wr |=> !master_select_o;
  endproperty
  a_mst_arb: assert property (p_mst_arb) else $error("master kept after loss");
  property p_mst_stop;
    master_select_o && stop_done_i && !uc_wr |=> !master_select_o;
  endproperty
  a_mst_stop: assert property (p_mst_stop) else $error("master kept after stop");
  property p_stt_clr;
    start_req_o && start_done_i && !tc_wr |=> !start_req_o;
  endproperty
  a_stt_clr: assert property (p_stt_clr) else $error("start bit not cleared");
  property p_stp_clr;
    stop_req_o && stop_done_i && !tc_wr |=> !stop_req_o;
  endproperty
  a_stp_clr: assert property (p_stp_clr) else $error("stop bit not cleared");
  property p_stb_val;
    start_byte_o == `ISC_START_BYTE_VAL;
  endproperty
  a_stb_val: assert property (p_stb_val) else $error("start byte value wrong");
  property p_loop;
    loopback_o |-> master_select_o && transmit_dir_o;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback outside master tx");
  property p_txdma;
    tx_dma_req_o |-> !tx_irq_gate_o;
  endproperty
  a_txdma: assert property (p_txdma) else $error("tx ready not masked");
  property p_rxdma;
    rx_dma_req_o |-> !rx_irq_gate_o;
  endproperty
  a_rxdma: assert property (p_rxdma) else $error("rx ready not masked");
  property p_own;
    reg_rd_i && reg_addr_i == `ISC_ADDR_OWN_ADDR |=> reg_rdata_o[15:7] == 9'h000;
  endproperty
  a_own: assert property (p_own) else $error("own address upper bits set");
endmodule // isc_ctrl_chk
`default_nettype wire

// >>> tb/isc_bus_model.sv
/*
  Stand-in for the shift engine and two-wire bus beside the register block.
  Assumes one START or STOP command is pending at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module isc_bus_model (
  input  wire logic       clk_sys_i,
  input  wire logic       arst_n_i,
  input  wire logic       start_req_i,
  input  wire logic       stop_req_i,
  input  wire logic       scl_oe_n_i,
  input  wire logic [3:0] delay_i,
  output logic            start_done_o,
  output logic            stop_done_o,
  output logic            start_seen_o,
  output logic            stop_seen_o,
  output logic            active_o,
  output logic            aux_tick_o,
  output wire logic       sub_tick_o,
  output wire logic       scl_o,
  output wire logic       sda_o
);
  logic [1:0] ph;
  logic       k;
  logic [3:0] cnt;
  // Pull-ups: a released line reads high
  assign scl_o = scl_oe_n_i;
  assign sda_o = 1'b1;
  assign sub_tick_o = 1'b1;
  // Answer after delay_i cycles, then wait for the command bit to drop
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {ph, k, cnt} <= 7'h00;
      {start_done_o, stop_done_o, start_seen_o, stop_seen_o, active_o, aux_tick_o} <= 6'h00;
    end else begin
      {start_done_o, stop_done_o, start_seen_o, stop_seen_o} <= 4'h0;
      aux_tick_o <= ~aux_tick_o;
      case (ph)
        2'h0: if (start_req_i || stop_req_i) begin
          ph <= 2'h1;
          k <= stop_req_i;
          cnt <= delay_i;
        end
        2'h1: if (cnt != 4'h0) begin
          cnt <= cnt - 4'h1;
        end else begin
          {stop_done_o, stop_seen_o} <= {2{k}};
          {start_done_o, start_seen_o} <= {2{~k}};
          active_o <= ~k;
          ph <= 2'h2;
        end
        default: if (k ? !stop_req_i : !start_req_i) begin
          ph <= 2'h0;
        end
      endcase
    end
  end
endmodule // isc_bus_model
`default_nettype wire

// >>> tb/tb_top.sv
/*
  Self-checking bench: register model compared at every read.
  Assumes isc_regs.vh offsets, a 100 MHz clock and the bus stand-in.
*/
`timescale 1ns/1ps
`default_nettype none
`include "isc_regs.vh"
module tb_top;
  localparam logic [7:0] UC = `ISC_ADDR_UNIT_CTL;
  localparam logic [7:0] TC = `ISC_ADDR_XFER_CTL;
  localparam logic [7:0] ST = `ISC_ADDR_DATA_STAT;
  localparam logic [7:0] DT = `ISC_ADDR_DATA;
  localparam logic [7:0] SH = `ISC_ADDR_SCL_HIGH;
  localparam logic [7:0] RA [10] = '{UC, TC, ST, 8'h73, SH, 8'h75, DT, 8'h52, 8'h18, 8'h40};
  localparam logic [7:0] RW [5] = '{SH, 8'h75, 8'h73, 8'h52, 8'h18};
  // Last two entries raise both DMA selects so the ready-enable masking is exercised
  localparam logic [7:0] MODES [6] = '{8'h04, 8'h00, 8'h27, 8'h27, 8'hce, 8'hef};
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        bw = 1'b0, we = 1'b0, re = 1'b0, txie = 1'b0, rxie = 1'b0;
  logic [2:0]  ev = 3'h0;
  logic [3:0]  dly = 4'h0;
  logic [31:0] seed = 32'h04e1;
  logic [15:0] m [256];
  logic        first = 1'b1, mbb = 1'b0, mudf = 1'b0, movr = 1'b0;
  int          n_mismatch = 0, check_count = 0;
  wire logic [15:0] rdata;
  wire logic   sreq, preq, oe_n, sdone, pdone, sseen, pseen, act, aux, sub, scl, sda;

  always #5 clk_sys_i = ~clk_sys_i;

  isc_ctrl dut (
    .clk_sys_i, .arst_n_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_byte_wr_i(bw),
    .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdata), .aux_clk_tick_i(aux),
    .sub_main_clock_tick_i(sub), .scl_pin_i(scl), .sda_pin_i(sda), .start_seen_i(sseen),
    .stop_seen_i(pseen), .arb_lost_i(ev[2]), .start_done_i(sdone), .stop_done_i(pdone),
    .tx_starved_i(ev[1]), .rx_overrun_i(ev[0]), .rx_byte_i(1'b0), .rx_word_i(1'b0),
    .rx_data_i(16'h0000), .engine_active_i(act), .tx_ready_irq_enable_i(txie),
    .rx_ready_irq_enable_i(rxie), .i2c_mode_o(), .spi_mode_o(), .uart_mode_o(),
    .ten_bit_address_select_o(), .master_select_o(), .transmit_dir_o(), .loopback_o(),
    .start_req_o(sreq), .stop_req_o(preq), .start_byte_req_o(), .start_byte_o(),
    .count_active_o(), .byte_count_o(), .tx_data_o(), .own_address_o(), .tx_dma_req_o(),
    .rx_dma_req_o(), .tx_irq_gate_o(), .rx_irq_gate_o(), .use_ext_scl_o(),
    .bit_tick_o(), .scl_out_o(), .scl_oe_n_o(oe_n));

  isc_bus_model u_bus (
    .clk_sys_i, .arst_n_i, .start_req_i(sreq), .stop_req_i(preq), .scl_oe_n_i(oe_n),
    .delay_i(dly), .start_done_o(sdone), .stop_done_o(pdone), .start_seen_o(sseen),
    .stop_seen_o(pseen), .active_o(act), .aux_tick_o(aux), .sub_tick_o(sub),
    .scl_o(scl), .sda_o(sda));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Random interrupt enables each cycle; tasks borrow seed bits for data
  always @(posedge clk_sys_i) begin
    seed <= lfsr(seed);
    txie <= seed[3];
    rxie <= seed[9];
  end

  // Bus busy: stop wins, a disabled module never shows busy
  always @(posedge clk_sys_i) begin
    if (sseen && m[UC][0]) mbb = 1'b1;
    if (pseen) mbb = 1'b0;
  end

  function automatic logic [15:0] exp(input logic [7:0] a);
    if (a == ST) return {10'h000, act, 2'h0, mudf, movr, mbb};
    return m[a];
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic b = 1'b0);
    logic u;
    u = m[UC][0];
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    bw <= b;
    we <= 1'b1;
    @(posedge clk_sys_i);
    we <= 1'b0;
    case (a)
      UC: begin
        m[a] = {8'h00, d[7:0]};
        if (first && d[`ISC_UC_TWO_WIRE] && d[`ISC_UC_SYNC]) begin
          m[a][0] = 1'b0;
          first = 1'b0;
        end
        if (!m[a][0]) {mbb, mudf, movr} = 3'h0;
      end
      TC: m[a] = {8'h00, u ? m[a][7:3] : d[7:3], d[2:0]};
      SH, 8'h75: if (!u) m[a] = {8'h00, d[7:0]};
      DT: if (!m[TC][7]) m[a] = {8'h00, d[7:0]};
        else if (!b) m[a] = d;
      8'h18: m[a] = d & `ISC_OWN_ADDR_MASK;
      8'h52, 8'h73: m[a] = {8'h00, d[7:0]};
      default: ;
    endcase
  endtask

  // Clock-held-low is masked: it depends on pin synchroniser lag
  task automatic rd(input logic [7:0] a);
    logic [15:0] k;
    k = (a == ST) ? 16'hffef : 16'hffff;
    @(posedge clk_sys_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clk_sys_i);
    re <= 1'b0;
    #1;
    chk(rdata & k, exp(a) & k);
  endtask

  task automatic cmd(input logic [2:0] c, input logic [3:0] d);
    dly <= d;
    wr(TC, {8'h00, m[TC][7:3], c});
    #1;
    for (int i = 0; i < 40 && (sreq || preq); i++) @(posedge clk_sys_i);
    repeat (3) @(posedge clk_sys_i);
    m[TC][2:0] = 3'h0;
    if (c[1]) m[UC][1] = 1'b0;
    rd(TC);
    rd(UC);
    rd(ST);
  endtask

  task automatic pulse(input logic [2:0] e);
    @(posedge clk_sys_i);
    ev <= e;
    @(posedge clk_sys_i);
    ev <= 3'h0;
    if (e[2]) m[UC][1] = 1'b0;
    mudf = mudf | e[1];
    movr = movr | e[0];
    rd(e[2] ? UC : ST);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Whole run is near 200 cycles; this cuts a hang short
  initial begin
    #(20000 * 10);
    n_mismatch++;
    finish_test();
  end

  initial begin
    foreach (m[i]) m[i] = 16'h0000;
    m[UC] = {8'h00, `ISC_UC_RESET};
    repeat (8) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    foreach (RA[i]) rd(RA[i]);
    // First two-wire write drops the enable bit
    foreach (MODES[i]) begin
      wr(UC, {8'h00, MODES[i]});
      rd(UC);
    end
    wr(UC, 16'h0026);
    for (int c = 0; c < 4; c++) begin
      wr(TC, {8'h00, 2'h2, c[1:0], 4'h8});
      rd(TC);
    end
    // Even random values keep word-mode counts legal
    foreach (RW[i]) begin
      wr(RW[i], seed[15:0] & 16'hfffe);
      rd(RW[i]);
    end
    wr(DT, 16'ha5c3);
    wr(DT, 16'h0011, 1'b1);
    rd(DT);
    wr(UC, 16'h0027);
    wr(TC, 16'h0000);
    wr(SH, 16'h00ff);
    rd(TC);
    rd(SH);
    cmd(3'h1, 4'h0);
    cmd(3'h5, 4'h6);
    cmd(3'h2, 4'h9);
    wr(UC, 16'h0027);
    pulse(3'h4);
    pulse(3'h3);
    wr(ST, 16'hffff);
    rd(ST);
    wr(UC, 16'h0026);
    rd(ST);
    wr(TC, 16'h0038);
    wr(DT, 16'h1234);
    rd(DT);
    finish_test();
  end
endmodule // tb_top

bind isc_ctrl isc_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (
  .clk_sys_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .arb_lost_i, .start_done_i, .stop_done_i, .i2c_mode_o, .uart_mode_o, .master_select_o,
  .transmit_dir_o, .loopback_o, .start_req_o, .stop_req_o, .start_byte_o, .tx_dma_req_o,
  .rx_dma_req_o, .tx_irq_gate_o, .rx_irq_gate_o);
`default_nettype wire
